// ---- src/cbl_pkg.sv ----
// Purpose: constants for the branch and load execution block
// Assumes: 8-bit data, word-addressed program counter
// Notes:   opcode field layout follows the core's 16-bit encoding
package cbl_pkg;
  localparam int PC_W   = 16;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  // Status flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  // Opcode match patterns
  localparam logic [15:0] BRBC_MASK  = 16'hFC00;
  localparam logic [15:0] BRBC_PAT   = 16'hF400;
  localparam logic [15:0] BRBS_PAT   = 16'hF000;
  localparam logic [15:0] COPY_MASK  = 16'hFC00;
  localparam logic [15:0] COPY_PAT   = 16'h2C00;
  localparam logic [15:0] PAIR_MASK  = 16'hFF00;
  localparam logic [15:0] PAIR_PAT   = 16'h0100;
  localparam logic [15:0] IMM_MASK   = 16'hF000;
  localparam logic [15:0] IMM_PAT    = 16'hE000;
  localparam logic [15:0] LDP_MASK   = 16'hFE00;
  localparam logic [15:0] LDP_PAT    = 16'h9000;
  localparam logic [15:0] DISP_MASK  = 16'hD200;
  localparam logic [15:0] DISP_PAT   = 16'h8000;
  // Pointer register indices (low byte)
  localparam logic [4:0] PTR_X = 5'h1A;
  localparam logic [4:0] PTR_Y = 5'h1C;
  localparam logic [4:0] PTR_Z = 5'h1E;
  // Pointer mode codes from opcode bits [3:0]
  localparam logic [3:0] PM_X     = 4'hC;
  localparam logic [3:0] PM_XINC  = 4'hD;
  localparam logic [3:0] PM_XDEC  = 4'hE;
  localparam logic [3:0] PM_YINC  = 4'h9;
  localparam logic [3:0] PM_YDEC  = 4'hA;
  localparam logic [3:0] PM_ZINC  = 4'h1;
  localparam logic [3:0] PM_ZDEC  = 4'h2;
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;
endpackage

// ---- src/cbl_branch_cond.sv ----
// Purpose: evaluates the condition of a flag-testing relative branch
// Assumes: flags are the current status register
// Notes:   purely combinational
`timescale 1ns/1ps
module cbl_branch_cond (
  // Decode
  input  wire logic [2:0] i_sel,
  input  wire logic       i_when_set,
  // Flags
  input  wire logic [7:0] i_flags,
  // Result
  output logic            o_take
);
  wire flag_sel = i_flags[i_sel];
  assign o_take = i_when_set ? flag_sel : ~flag_sel;
endmodule

// ---- src/cbl_exec.sv ----
// Purpose: executes flag-testing relative branches, register moves and
//          pointer-based data memory loads
// Assumes: one instruction offered at a time with i_valid; memory read
//          data stands in the same cycle as o_mem_rd
// Notes:   flags never written here; S flag (bit 4) is N xor V
// Operation
// - Branch on carry clear jumps by offset plus one when C is 0, in 1 or 2 clocks.
// - Same-or-higher branch acts as carry clear and leaves flags alone.
// - Unsigned lower branch jumps only when C is 1, else falls through.
// - Minus branch jumps only when N is 1, 1 clock not taken and 2 taken.
// - Plus branch jumps only when N is 0 and changes no flag.
// - Signed greater-or-equal branch jumps when N xor V is 0, in 1 or 2 clocks.
// - Signed less-than branch jumps when N xor V is 1, else falls through.
// - Half-carry-set branch jumps only when H is 1, flags unchanged, 1 or 2 clocks.
// - Half-carry-clear branch jumps only when H is 0, flags unchanged.
// - Transfer-set branch jumps only when T is 1, else next instruction.
// - Transfer-clear branch jumps only when T is 0, flags unchanged.
// - Overflow-set branch jumps only when V is 1, 1 clock not taken, 2 taken.
// - Pre-decrement loads decrement the pointer then read at the new address, 2 clocks.
// - Post-increment loads read at the pointer then increment it, 2 clocks.
// - Displacement loads read at pointer plus q and keep the pointer, 2 clocks.
`timescale 1ns/1ps
module cbl_exec (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_nrst,
  // Instruction
  input  wire logic                        i_valid,
  input  wire logic [15:0]                 i_instr,
  output logic                             o_ready,
  // Status flags
  input  wire logic [7:0]                  i_flags,
  // Register file
  output logic [4:0]                       o_rf_ra,
  input  wire logic [cbl_pkg::DATA_W-1:0]  i_rf_rdata_a,
  output logic [4:0]                       o_rf_rb,
  input  wire logic [cbl_pkg::DATA_W-1:0]  i_rf_rdata_b,
  output logic [4:0]                       o_ptr_idx,
  input  wire logic [cbl_pkg::ADDR_W-1:0]  i_ptr_val,
  output logic                             o_rf_we,
  output logic [4:0]                       o_rf_wa,
  output logic [cbl_pkg::DATA_W-1:0]       o_rf_wdata,
  output logic                             o_rf_we2,
  output logic [4:0]                       o_rf_wa2,
  output logic [cbl_pkg::DATA_W-1:0]       o_rf_wdata2,
  output logic                             o_ptr_we,
  output logic [cbl_pkg::ADDR_W-1:0]       o_ptr_wdata,
  // Data memory
  output logic                             o_mem_rd,
  output logic [cbl_pkg::ADDR_W-1:0]       o_mem_addr,
  input  wire logic [cbl_pkg::DATA_W-1:0]  i_mem_rdata,
  // Program counter
  output logic [cbl_pkg::PC_W-1:0]         o_pc,
  output logic                             o_flags_we
);
  typedef enum logic [1:0] {
    CBL_IDLE  = 2'b00,
    CBL_BRTK  = 2'b01,
    CBL_LOAD  = 2'b10
  } cbl_state_e;

  cbl_state_e                    state_q, state_d;
  logic [cbl_pkg::PC_W-1:0]      pc_q, pc_d;
  logic [cbl_pkg::PC_W-1:0]      target_q, target_d;
  logic [4:0]                    load_dst_q;
  logic [4:0]                    ptr_idx_q;
  logic                          ptr_we_q;
  logic [cbl_pkg::ADDR_W-1:0]    ptr_wdata_q;
  logic                          rf_we_q, rf_we2_q;
  logic [4:0]                    rf_wa_q, rf_wa2_q;
  logic [cbl_pkg::DATA_W-1:0]    rf_wd_q, rf_wd2_q;
  logic                          mem_rd_q;
  logic [cbl_pkg::ADDR_W-1:0]    mem_addr_q;

  // Decode
  wire is_br   = (i_instr & cbl_pkg::BRBC_MASK) == cbl_pkg::BRBC_PAT
               || (i_instr & cbl_pkg::BRBC_MASK) == cbl_pkg::BRBS_PAT;
  wire is_copy = (i_instr & cbl_pkg::COPY_MASK) == cbl_pkg::COPY_PAT;
  wire is_pair = (i_instr & cbl_pkg::PAIR_MASK) == cbl_pkg::PAIR_PAT;
  wire is_imm  = (i_instr & cbl_pkg::IMM_MASK) == cbl_pkg::IMM_PAT;
  wire is_ldp  = (i_instr & cbl_pkg::LDP_MASK) == cbl_pkg::LDP_PAT;
  wire is_disp = (i_instr & cbl_pkg::DISP_MASK) == cbl_pkg::DISP_PAT;
  wire [3:0] pmode = i_instr[3:0];
  wire [4:0] rd    = i_instr[8:4];
  wire [4:0] rr    = {i_instr[9], i_instr[3:0]};
  wire [7:0] kimm  = {i_instr[11:8], i_instr[3:0]};
  wire [5:0] disp  = {i_instr[13], i_instr[11:10], i_instr[2:0]};
  wire       post_inc = pmode == cbl_pkg::PM_XINC || pmode == cbl_pkg::PM_YINC
                     || pmode == cbl_pkg::PM_ZINC;
  wire       pre_dec  = pmode == cbl_pkg::PM_XDEC || pmode == cbl_pkg::PM_YDEC
                     || pmode == cbl_pkg::PM_ZDEC;
  // Direct-address and reserved codes fall through as unknown opcodes
  wire       ldp_ok   = post_inc || pre_dec
                     || pmode == cbl_pkg::PM_X;
  wire       is_load  = (is_ldp && ldp_ok) || is_disp;
  wire [4:0] ldp_ptr  = (pmode[3:2] == 2'b11) ? cbl_pkg::PTR_X :
                        (pmode[3] ? cbl_pkg::PTR_Y : cbl_pkg::PTR_Z);
  wire [4:0] disp_ptr = i_instr[3] ? cbl_pkg::PTR_Y : cbl_pkg::PTR_Z;
  wire [4:0] ptr_sel  = is_ldp ? ldp_ptr : disp_ptr;

  // Condition: bit 10 clear tests for set; S flag gives N xor V
  wire       take;
  wire [7:0] flags_s = {i_flags[7:5], i_flags[cbl_pkg::FLG_N] ^ i_flags[cbl_pkg::FLG_V],
                        i_flags[3:0]};
  cbl_branch_cond u_cond (
    .i_sel      (i_instr[2:0]),
    .i_when_set (~i_instr[10]),
    .i_flags    (flags_s),
    .o_take     (take)
  );

  // Signed word offset from incremented PC
  wire [cbl_pkg::PC_W-1:0] off_ext = {{(cbl_pkg::PC_W-7){i_instr[9]}}, i_instr[9:3]};
  wire [cbl_pkg::PC_W-1:0] pc_inc  = pc_q + 16'h0001;
  wire [cbl_pkg::PC_W-1:0] br_tgt  = pc_inc + off_ext;

  wire [cbl_pkg::ADDR_W-1:0] ptr_dec = i_ptr_val - 16'h0001;
  wire [cbl_pkg::ADDR_W-1:0] ptr_inc = i_ptr_val + 16'h0001;
  wire [cbl_pkg::ADDR_W-1:0] ptr_dsp = i_ptr_val + {10'h000, disp};
  wire                       idle    = state_q == CBL_IDLE;
  wire                       go      = idle && i_valid;

  assign o_ready    = idle;
  // Pair copy reads the source high byte through port a
  assign o_rf_ra    = is_pair ? {i_instr[3:0], 1'b1} : rd;
  assign o_rf_rb    = is_pair ? {i_instr[3:0], 1'b0} : rr;
  // Pointer index held through the load so the update lands on it
  assign o_ptr_idx  = (state_q == CBL_LOAD) ? ptr_idx_q : ptr_sel;
  assign o_flags_we = 1'b0;

  always_comb begin
    state_d  = state_q;
    pc_d     = pc_q;
    target_d = target_q;
    case (state_q)
      CBL_IDLE: begin
        if (i_valid) begin
          if (is_br && take) begin
            target_d = br_tgt;
            state_d  = CBL_BRTK;
          end else if (is_load) begin
            state_d  = CBL_LOAD;
          end else begin
            pc_d     = pc_inc;
          end
        end
      end
      CBL_BRTK: begin
        pc_d    = target_q;
        state_d = CBL_IDLE;
      end
      CBL_LOAD: begin
        pc_d    = pc_inc;
        state_d = CBL_IDLE;
      end
      default: state_d = CBL_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q  <= CBL_IDLE;
      pc_q     <= cbl_pkg::PC_RST;
      target_q <= cbl_pkg::PC_RST;
    end else begin
      state_q  <= state_d;
      pc_q     <= pc_d;
      target_q <= target_d;
    end
  end

  // Memory access and pointer update issued on the second load clock
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mem_rd_q    <= 1'b0;
      mem_addr_q  <= 16'h0000;
      ptr_we_q    <= 1'b0;
      ptr_wdata_q <= 16'h0000;
      load_dst_q  <= 5'h00;
      ptr_idx_q   <= 5'h00;
    end else begin
      mem_rd_q   <= go && is_load;
      ptr_we_q   <= go && is_ldp && (post_inc || pre_dec);
      load_dst_q <= rd;
      ptr_idx_q  <= ptr_sel;
      if (is_ldp) begin
        mem_addr_q  <= pre_dec ? ptr_dec : i_ptr_val;
        ptr_wdata_q <= pre_dec ? ptr_dec : ptr_inc;
      end else begin
        mem_addr_q  <= ptr_dsp;
        ptr_wdata_q <= i_ptr_val;
      end
    end
  end

  // Register writes: single clock moves, load data on the second clock
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rf_we_q  <= 1'b0;
      rf_we2_q <= 1'b0;
      rf_wa_q  <= 5'h00;
      rf_wa2_q <= 5'h00;
      rf_wd_q  <= 8'h00;
      rf_wd2_q <= 8'h00;
    end else begin
      rf_we_q  <= go && (is_copy || is_pair || is_imm);
      rf_we2_q <= go && is_pair;
      rf_wa_q  <= is_imm ? {1'b1, i_instr[7:4]} :
                  (is_pair ? {i_instr[7:4], 1'b0} : rd);
      rf_wa2_q <= {i_instr[7:4], 1'b1};
      rf_wd_q  <= is_imm ? kimm : i_rf_rdata_b;
      rf_wd2_q <= i_rf_rdata_a;
    end
  end

  // Load data is written back in the same cycle as the read
  assign o_rf_we     = rf_we_q || (state_q == CBL_LOAD);
  assign o_rf_wa     = (state_q == CBL_LOAD) ? load_dst_q : rf_wa_q;
  assign o_rf_wdata  = (state_q == CBL_LOAD) ? i_mem_rdata : rf_wd_q;
  assign o_rf_we2    = rf_we2_q;
  assign o_rf_wa2    = rf_wa2_q;
  assign o_rf_wdata2 = rf_wd2_q;
  assign o_ptr_we    = ptr_we_q;
  assign o_ptr_wdata = ptr_wdata_q;
  assign o_mem_rd    = mem_rd_q;
  assign o_mem_addr  = mem_addr_q;
  assign o_pc        = pc_q;
endmodule

// ---- testbench/cbl_mem_model.sv ----
// Purpose: register file and data memory beside cbl_exec
// Assumes: reads combinational, writes on the rising edge
// Notes:   byte at A is A[7:0]^A5; idle bus shows inverted last read
`timescale 1ns/1ps
module cbl_mem_model (
  // Clock
  input  wire logic        i_clk,
  // Register reads
  input  wire logic [4:0]  i_ra,
  output logic      [7:0]  o_rda,
  input  wire logic [4:0]  i_rb,
  output logic      [7:0]  o_rdb,
  input  wire logic [4:0]  i_pidx,
  output logic      [15:0] o_pval,
  // Register writes
  input  wire logic        i_we,
  input  wire logic [4:0]  i_wa,
  input  wire logic [7:0]  i_wd,
  input  wire logic        i_we2,
  input  wire logic [4:0]  i_wa2,
  input  wire logic [7:0]  i_wd2,
  input  wire logic        i_pwe,
  input  wire logic [15:0] i_pwd,
  // Data memory
  input  wire logic        i_rd,
  input  wire logic [15:0] i_addr,
  output logic      [7:0]  o_mrd
);
  logic [7:0] rf [32];
  logic [7:0] last = 8'h00;
  initial foreach (rf[i]) rf[i] = 8'(i * 7);
  assign o_rda = rf[i_ra];
  assign o_rdb = rf[i_rb];
  assign o_pval = {rf[i_pidx + 5'h01], rf[i_pidx]};
  assign o_mrd = i_rd ? (i_addr[7:0] ^ 8'hA5) : ~last;
  always @(posedge i_clk) begin
    if (i_rd) last <= o_mrd;
    if (i_we) rf[i_wa] <= i_wd;
    if (i_we2) rf[i_wa2] <= i_wd2;
    if (i_pwe) {rf[i_pidx + 5'h01], rf[i_pidx]} <= i_pwd;
  end
endmodule

// ---- testbench/cbl_exec_chk.sv ----
// Purpose: port timing checks for cbl_exec
// Assumes: one clock, synchronous active-low reset
// Notes:   S flag taken as N xor V
`timescale 1ns/1ps
module cbl_exec_chk (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_nrst,
  // Instruction
  input wire logic        i_valid,
  input wire logic [15:0] i_instr,
  input wire logic        o_ready,
  input wire logic [7:0]  i_flags,
  // Memory side
  input wire logic [15:0] i_ptr_val,
  input wire logic [15:0] o_ptr_wdata,
  input wire logic        o_ptr_we,
  input wire logic        o_mem_rd,
  input wire logic [15:0] o_mem_addr,
  input wire logic [7:0]  i_mem_rdata,
  input wire logic        o_rf_we,
  input wire logic [7:0]  o_rf_wdata,
  // Program counter
  input wire logic [15:0] o_pc,
  input wire logic        o_flags_we
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire logic [7:0]  fl = {i_flags[7:5], i_flags[2] ^ i_flags[3], i_flags[3:0]};
  wire logic        acc = i_valid && o_ready;
  wire logic        br = acc && (i_instr[15:11] == 5'h1E);
  wire logic        tk = fl[i_instr[2:0]] ^ i_instr[10];
  wire logic [15:0] tgt = o_pc + 16'h0001 + {{9{i_instr[9]}}, i_instr[9:3]};
  wire logic        ldp = acc && (i_instr[15:9] == 7'h48);
  wire logic        dec = ldp && (i_instr[3:0] inside {4'hE, 4'hA, 4'h2});
  wire logic        inc = ldp && (i_instr[3:0] inside {4'hD, 4'h9, 4'h1});
  wire logic        dsp = acc && ((i_instr & 16'hD200) == 16'h8000);
  wire logic        load = dec || inc || dsp || (ldp && i_instr[3:0] == 4'hC);
  wire logic [15:0] qa = i_ptr_val + {i_instr[13], i_instr[11:10], i_instr[2:0]};
  chk_flags_kept: assert property (o_flags_we == 1'b0)
    else $error("flag write seen");
  chk_branch_fall: assert property (br && !tk |=> o_ready && o_pc == $past(o_pc) + 16'h0001)
    else $error("untaken branch wrong");
  chk_branch_take: assert property (br && tk |=> !o_ready ##1 o_ready && o_pc == $past(tgt, 2))
    else $error("taken branch wrong");
  chk_load_dec: assert property (dec |=> o_mem_rd && o_ptr_we &&
    o_mem_addr == $past(i_ptr_val) - 16'h0001 && o_ptr_wdata == o_mem_addr)
    else $error("pre-decrement load wrong");
  chk_load_inc: assert property (inc |=> o_mem_rd && o_ptr_we &&
    o_mem_addr == $past(i_ptr_val) && o_ptr_wdata == o_mem_addr + 16'h0001)
    else $error("post-increment load wrong");
  chk_load_disp: assert property (dsp |=> o_mem_rd && !o_ptr_we && o_mem_addr == $past(qa))
    else $error("displacement load wrong");
  chk_load_data: assert property (o_mem_rd |-> o_rf_we && o_rf_wdata == i_mem_rdata)
    else $error("load data not written");
  chk_load_pc: assert property (load |=> !o_ready ##1 o_ready && o_pc == $past(o_pc, 2) + 16'h0001)
    else $error("load timing wrong");
endmodule
bind cbl_exec cbl_exec_chk u_chk (.i_clk, .i_nrst, .i_valid, .i_instr, .o_ready, .i_flags,
  .i_ptr_val, .o_ptr_wdata, .o_ptr_we, .o_mem_rd, .o_mem_addr, .i_mem_rdata, .o_rf_we,
  .o_rf_wdata, .o_pc, .o_flags_we);

// ---- testbench/test_cbl_exec.sv ----
// Purpose: self-checking bench for cbl_exec
// Assumes: partner returns memory data in the read cycle
// Notes:   pointers are set up by immediate loads first
`timescale 1ns/1ps
module test_cbl_exec;
  logic             i_clk = 1'b0;
  logic             i_nrst = 1'b0;
  logic             i_valid = 1'b0;
  logic [15:0]      i_instr = 16'h0000;
  logic [7:0]       i_flags = 8'h00;
  wire logic        rdy, we, we2, pwe, mrd_s, fwe;
  wire logic [4:0]  ra, rb, pidx, wa, wa2;
  wire logic [7:0]  rda, rdb, wd, wd2, mrd;
  wire logic [15:0] pval, pwd, maddr, pc;
  int               err_count = 0;
  int               comparisons = 0;
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
  cbl_exec DUT (.i_clk, .i_nrst, .i_valid, .i_instr, .o_ready(rdy), .i_flags,
    .o_rf_ra(ra), .i_rf_rdata_a(rda), .o_rf_rb(rb), .i_rf_rdata_b(rdb), .o_ptr_idx(pidx),
    .i_ptr_val(pval), .o_rf_we(we), .o_rf_wa(wa), .o_rf_wdata(wd), .o_rf_we2(we2),
    .o_rf_wa2(wa2), .o_rf_wdata2(wd2), .o_ptr_we(pwe), .o_ptr_wdata(pwd), .o_mem_rd(mrd_s),
    .o_mem_addr(maddr), .i_mem_rdata(mrd), .o_pc(pc), .o_flags_we(fwe));
  cbl_mem_model PM (.i_clk, .i_ra(ra), .o_rda(rda), .i_rb(rb), .o_rdb(rdb), .i_pidx(pidx),
    .o_pval(pval), .i_we(we), .i_wa(wa), .i_wd(wd), .i_we2(we2), .i_wa2(wa2), .i_wd2(wd2),
    .i_pwe(pwe), .i_pwd(pwd), .i_rd(mrd_s), .i_addr(maddr), .o_mrd(mrd));
  initial forever #5 i_clk = ~i_clk;
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One instruction, returns clocks until ready again
  task automatic issue(input logic [15:0] ins, output int cyc);
    @(negedge i_clk);
    i_valid = 1'b1;
    i_instr = ins;
    @(negedge i_clk);
    i_valid = 1'b0;
    cyc = 1;
    while (rdy !== 1'b1 && cyc < 20) begin
      @(negedge i_clk);
      cyc++;
    end
    if (cyc >= 20) begin err_count++; final_report(); end
    // Let the register write-back edge pass
    @(negedge i_clk);
  endtask
  task automatic t_branch();
    logic [7:0]  fv [4] = '{8'h00, 8'hFF, 8'h08, 8'h64};
    logic [15:0] pc0, k;
    logic        tk;
    int          cyc;
    for (int s = 0; s < 16; s++) begin
      for (int f = 0; f < 4; f++) begin
        i_flags = fv[f];
        pc0 = pc;
        k = f[0] ? 16'hFFFD : 16'h0005;
        tk = ((s[3:1] == 4) ? fv[f][2] ^ fv[f][3] : fv[f][s[3:1]]) ^ s[0];
        issue({5'h1E, s[0], k[6:0], s[3:1]}, cyc);
        `CHK("branch pc", pc0 + 16'h0001 + (tk ? k : 16'h0000), pc)
        `CHK("branch clocks", tk ? 2 : 1, cyc)
      end
    end
    $display("branch test done");
  endtask
  task automatic run_load(input logic [15:0] ins, input int d, input logic [15:0] a,
                          input int p, input logic [15:0] ptr);
    int cyc;
    issue(ins, cyc);
    `CHK("load clocks", 2, cyc)
    `CHK("load data", a[7:0] ^ 8'hA5, PM.rf[d])
    `CHK("pointer", ptr, {PM.rf[p + 1], PM.rf[p]})
  endtask
  task automatic t_loads();
    logic [7:0] kv [6] = '{8'h40, 8'h01, 8'h80, 8'h02, 8'h10, 8'h00};
    int         cyc;
    for (int i = 0; i < 6; i++) begin
      issue({4'hE, kv[i][7:4], 4'(10 + i), kv[i][3:0]}, cyc);
      `CHK("immediate", kv[i], PM.rf[26 + i])
      `CHK("immediate clocks", 1, cyc)
    end
    run_load({7'h48, 5'd1, 4'hE}, 1, 16'h013F, 26, 16'h013F);
    run_load({7'h48, 5'd2, 4'hD}, 2, 16'h013F, 26, 16'h0140);
    run_load({7'h48, 5'd3, 4'hC}, 3, 16'h0140, 26, 16'h0140);
    run_load({7'h48, 5'd4, 4'hA}, 4, 16'h027F, 28, 16'h027F);
    run_load({7'h48, 5'd5, 4'h9}, 5, 16'h027F, 28, 16'h0280);
    run_load(16'hA46B, 6, 16'h02AB, 28, 16'h0280);
    run_load({7'h48, 5'd7, 4'h2}, 7, 16'h000F, 30, 16'h000F);
    run_load({7'h48, 5'd8, 4'h1}, 8, 16'h000F, 30, 16'h0010);
    run_load(16'h8090, 9, 16'h0010, 30, 16'h0010);
    $display("load test done");
  endtask
  task automatic t_moves();
    int cyc;
    issue(16'h2CA1, cyc);
    `CHK("copy", 8'h9A, PM.rf[10])
    `CHK("copy clocks", 1, cyc)
    issue(16'h0161, cyc);
    `CHK("pair low", 8'h9A, PM.rf[12])
    `CHK("pair high", 8'hE5, PM.rf[13])
    `CHK("pair clocks", 1, cyc)
    i_nrst = 1'b0;
    repeat (2) @(negedge i_clk);
    `CHK("reset pc", 16'h0000, pc)
    `CHK("reset ready", 1'b1, rdy)
    i_nrst = 1'b1;
    $display("move and reset test done");
  endtask
  initial begin
    repeat (6) @(negedge i_clk);
    i_nrst = 1'b1;
    t_branch();
    t_loads();
    t_moves();
    final_report();
  end
endmodule
